/* hdl/cie_core.sv */
// execute stage for a subset of the 8-bit core instruction set
`timescale 1ns/10ps
`default_nettype none
module cie_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic insn_valid,
  input wire logic [13:0] insn,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pc_high_latch,
  input wire logic [14:0] top_of_stack,
  output logic [6:0] file_raddr,
  output logic [14:0] pc,
  output logic stack_pop,
  output cie_pkg::cie_fwr_s file_wr,
  output logic [7:0] working,
  output logic zero_flag,
  output logic carry_flag,
  output logic global_interrupt_enable,
  output logic flush
);
  import cie_pkg::*;

  typedef enum logic [1:0] {
    CIE_ST_EXEC = 2'b01,
    CIE_ST_SLOT = 2'b10
  } cie_state_e;

  cie_dec_s dec;
  cie_state_e state_r, state_nxt;
  logic [14:0] pc_r, pc_nxt;
  logic [7:0] working_r, working_nxt;
  logic zero_r, zero_nxt, carry_r, carry_nxt, gie_r, gie_nxt;
  logic pop_r, pop_nxt, flush_r, flush_nxt;
  cie_fwr_s fwr_r, fwr_nxt;
  logic [7:0] result;
  logic two_cycle;

  cie_decode u_decode (
    .insn(insn),
    .dec(dec)
  );

  // file read address follows the live instruction
  assign file_raddr = dec.faddr;

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    working_nxt = working_r;
    zero_nxt = zero_r;
    carry_nxt = carry_r;
    gie_nxt = gie_r;
    pop_nxt = 1'b0;
    flush_nxt = 1'b0;
    fwr_nxt = '0;
    result = 8'h00;
    two_cycle = 1'b0;
    unique case (state_r)
      CIE_ST_SLOT: begin
        // fetched word is discarded, no-operation slot
        state_nxt = CIE_ST_EXEC;
      end
      CIE_ST_EXEC: begin
        if (insn_valid) begin
          pc_nxt = pc_r + 15'h0001;
          unique case (dec.kind)
            CIE_K_DEC: begin
              result = file_rdata - 8'h01;
              two_cycle = is_zero(result);
            end
            CIE_K_INC: begin
              result = file_rdata + 8'h01;
              two_cycle = is_zero(result);
            end
            CIE_K_OR_LIT: begin
              result = working_r | dec.k[7:0];
              working_nxt = result;
              zero_nxt = is_zero(result);
            end
            CIE_K_OR_FILE: begin
              result = working_r | file_rdata;
              zero_nxt = is_zero(result);
            end
            CIE_K_ROT: begin
              result = {file_rdata[6:0], carry_r};
              carry_nxt = file_rdata[7];
            end
            CIE_K_BRANCH: begin
              pc_nxt = {pc_high_latch[CIE_LATCH_HI:CIE_LATCH_LO], dec.k};
              two_cycle = 1'b1;
            end
            CIE_K_RET: begin
              pc_nxt = top_of_stack;
              pop_nxt = 1'b1;
              two_cycle = 1'b1;
            end
            CIE_K_RET_INT: begin
              pc_nxt = top_of_stack;
              pop_nxt = 1'b1;
              gie_nxt = 1'b1;
              two_cycle = 1'b1;
            end
            CIE_K_RET_LIT: begin
              pc_nxt = top_of_stack;
              pop_nxt = 1'b1;
              working_nxt = dec.k[7:0];
              two_cycle = 1'b1;
            end
            default: begin
            end
          endcase
          if (dec.kind == CIE_K_DEC || dec.kind == CIE_K_INC ||
              dec.kind == CIE_K_OR_FILE || dec.kind == CIE_K_ROT) begin
            if (dec.dest_file) begin
              fwr_nxt.we = 1'b1;
              fwr_nxt.addr = dec.faddr;
              fwr_nxt.data = result;
            end else begin
              working_nxt = result;
            end
          end
          if (two_cycle) begin
            flush_nxt = 1'b1;
            state_nxt = CIE_ST_SLOT;
          end
        end
      end
      default: state_nxt = CIE_ST_EXEC;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= CIE_ST_EXEC;
      pc_r <= CIE_PC_RST;
      working_r <= CIE_W_RST;
      zero_r <= 1'b0;
      carry_r <= 1'b0;
      gie_r <= 1'b0;
      pop_r <= 1'b0;
      flush_r <= 1'b0;
      fwr_r <= '0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      working_r <= working_nxt;
      zero_r <= zero_nxt;
      carry_r <= carry_nxt;
      gie_r <= gie_nxt;
      pop_r <= pop_nxt;
      flush_r <= flush_nxt;
      fwr_r <= fwr_nxt;
    end
  end

  assign pc = pc_r;
  assign stack_pop = pop_r;
  assign file_wr = fwr_r;
  assign working = working_r;
  assign zero_flag = zero_r;
  assign carry_flag = carry_r;
  assign global_interrupt_enable = gie_r;
  assign flush = flush_r;
endmodule // cie_core
`default_nettype wire

/* hdl/cie_decode.sv */
// combinational instruction word decoder
`timescale 1ns/10ps
`default_nettype none
module cie_decode (
  input wire logic [13:0] insn,
  output cie_pkg::cie_dec_s dec
);
  import cie_pkg::*;
  always_comb begin
    dec.dest_file = insn[7];
    dec.faddr = insn[6:0];
    dec.k = insn[10:0];
    if (insn == CIE_OP_RETURN) begin
      dec.kind = CIE_K_RET;
    end else if (insn == CIE_OP_RET_INT) begin
      dec.kind = CIE_K_RET_INT;
    end else if (insn[13:11] == CIE_OP_BRANCH) begin
      dec.kind = CIE_K_BRANCH;
    end else begin
      unique case (insn[13:8])
        CIE_OP_DEC_SKIP: dec.kind = CIE_K_DEC;
        CIE_OP_INC_SKIP: dec.kind = CIE_K_INC;
        CIE_OP_OR_FILE: dec.kind = CIE_K_OR_FILE;
        CIE_OP_ROT_LEFT: dec.kind = CIE_K_ROT;
        CIE_OP_OR_LIT: dec.kind = CIE_K_OR_LIT;
        CIE_OP_RET_LIT: dec.kind = CIE_K_RET_LIT;
        // unsupported words run as no-operation
        default: dec.kind = CIE_K_NOP;
      endcase
    end
  end
endmodule // cie_decode
`default_nettype wire

/* pkg/cie_pkg.sv */
// shared constants and types for the core instruction execute block
package cie_pkg;
  localparam int CIE_FADDR_W = 7;
  localparam int CIE_PC_W = 15;
  localparam int CIE_INSN_W = 14;
  localparam logic [7:0] CIE_W_RST = 8'h00;
  localparam logic [14:0] CIE_PC_RST = 15'h0000;
  localparam int CIE_GIE_BIT = 7;
  localparam int CIE_LATCH_LO = 3;
  localparam int CIE_LATCH_HI = 6;
  // opcode patterns; file ops op[13:8] d[7] f[6:0], literal ops op[13:8] k[7:0], branch op[13:11] k[10:0]
  localparam logic [5:0] CIE_OP_DEC_SKIP = 6'h0b;
  localparam logic [5:0] CIE_OP_INC_SKIP = 6'h0f;
  localparam logic [5:0] CIE_OP_OR_FILE = 6'h04;
  localparam logic [5:0] CIE_OP_ROT_LEFT = 6'h0d;
  localparam logic [5:0] CIE_OP_OR_LIT = 6'h38;
  localparam logic [5:0] CIE_OP_RET_LIT = 6'h34;
  localparam logic [2:0] CIE_OP_BRANCH = 3'h5;
  localparam logic [13:0] CIE_OP_RETURN = 14'h0008;
  localparam logic [13:0] CIE_OP_RET_INT = 14'h0009;

  typedef enum logic [3:0] {
    CIE_K_NOP = 4'h0, CIE_K_DEC = 4'h1, CIE_K_INC = 4'h2, CIE_K_OR_LIT = 4'h3,
    CIE_K_OR_FILE = 4'h4, CIE_K_BRANCH = 4'h5, CIE_K_RET = 4'h6,
    CIE_K_RET_INT = 4'h7, CIE_K_RET_LIT = 4'h8, CIE_K_ROT = 4'h9
  } cie_kind_e;

  typedef struct packed {
    cie_kind_e kind;
    logic dest_file;
    logic [6:0] faddr;
    logic [10:0] k;
  } cie_dec_s;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } cie_fwr_s;
endpackage : cie_pkg

/* testbench/cie_core_assertions.sv */
// port checks for the execute stage
`timescale 1ns/10ps
`default_nettype none
module cie_core_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic insn_valid,
  input wire logic [13:0] insn,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pc_high_latch,
  input wire logic [14:0] top_of_stack,
  input wire logic [6:0] file_raddr,
  input wire logic [14:0] pc,
  input wire logic stack_pop,
  input wire cie_pkg::cie_fwr_s file_wr,
  input wire logic [7:0] working,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic global_interrupt_enable,
  input wire logic flush
);
  import cie_pkg::*;
  // taken only outside the slot; flush marks the slot edge
  logic tk;
  logic [5:0] op;
  assign tk = insn_valid & ~flush;
  assign op = insn[13:8];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_branch_target: assert property (
    tk && insn[13:11] == CIE_OP_BRANCH |=> flush &&
    pc == {$past(pc_high_latch[6:3]), $past(insn[10:0])})
    else $error("branch pc");
  a_slot_quiet: assert property (
    flush |=> !flush && $stable(pc) && $stable(working)) else $error("slot");
  a_dec_skip: assert property (
    tk && op == CIE_OP_DEC_SKIP |=> flush == ($past(file_rdata) == 8'h01)
    && $stable(zero_flag) && $stable(carry_flag)) else $error("dec skip");
  a_or_lit_zero: assert property (
    tk && op == CIE_OP_OR_LIT |=> working == ($past(working) | $past(insn[7:0]))
    && zero_flag == (working == 8'h00)) else $error("or literal");
  a_ret_int_enable: assert property (
    tk && insn == CIE_OP_RET_INT |=> global_interrupt_enable && stack_pop
    && pc == $past(top_of_stack)) else $error("interrupt return");
  a_return_pop: assert property (
    tk && insn == CIE_OP_RETURN |=> stack_pop && flush
    && pc == $past(top_of_stack)) else $error("return");
  a_ret_lit_load: assert property (
    tk && op == CIE_OP_RET_LIT |=> working == $past(insn[7:0])
    && pc == $past(top_of_stack)) else $error("literal return");
  a_rot_carry: assert property (
    tk && op == CIE_OP_ROT_LEFT && !insn[7] |=> !flush && carry_flag ==
    $past(file_rdata[7]) && working[0] == $past(carry_flag))
    else $error("rotate");
endmodule // cie_core_assertions
bind cie_core cie_core_assertions u_chk (.clock, .rst_n, .insn_valid, .insn,
  .file_rdata, .pc_high_latch, .top_of_stack, .file_raddr, .pc, .stack_pop,
  .file_wr, .working, .zero_flag, .carry_flag, .global_interrupt_enable, .flush);
`default_nettype wire

/* testbench/cie_core_bench.sv */
// self-checking bench for the execute stage
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module cie_core_bench;
  import cie_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic insn_valid = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [7:0] pc_high_latch = 8'h28;
  logic [7:0] file_rdata, working;
  logic [14:0] top_of_stack, pc, p;
  logic [6:0] file_raddr;
  logic stack_pop, zero_flag, carry_flag, global_interrupt_enable, flush, z;
  cie_fwr_s file_wr;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  cie_core uut (.clock, .rst_n, .insn_valid, .insn, .file_rdata,
    .pc_high_latch, .top_of_stack, .file_raddr, .pc, .stack_pop, .file_wr,
    .working, .zero_flag, .carry_flag, .global_interrupt_enable, .flush);
  cie_partner u_mem (.clock, .file_raddr, .file_wr, .stack_pop, .file_rdata,
    .top_of_stack);
  initial forever #25 clock = ~clock;
  // whole run is well under 100 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 400) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic drive(input logic [13:0] w);
    @(posedge clock);
    insn <= w;
    insn_valid <= 1'b1;
  endtask
  task automatic run(input logic [13:0] w);
    drive(w);
    @(posedge clock);
    insn_valid <= 1'b0;
    #1;
  endtask
  task automatic t_skip();
    u_mem.mem[10] = 8'h01;
    u_mem.mem[11] = 8'h05;
    u_mem.mem[12] = 8'hff;
    p = pc;
    run({CIE_OP_DEC_SKIP, 1'b1, 7'd10});
    `CHK("dec wr", {1'b1, 7'd10, 8'h00}, file_wr)
    `CHK("dec skip", 1'b1, flush)
    run({CIE_OP_DEC_SKIP, 1'b0, 7'd11});
    `CHK("dec w", 8'h04, working)
    `CHK("dec pc", p + 15'd2, pc)
    z = zero_flag;
    run({CIE_OP_INC_SKIP, 1'b0, 7'd12});
    `CHK("inc w", 8'h00, working)
    `CHK("inc skip", 1'b1, flush)
    `CHK("inc z", z, zero_flag)
  endtask
  task automatic t_or_branch();
    u_mem.mem[13] = 8'h50;
    run({CIE_OP_OR_LIT, 8'h00});
    `CHK("or lit z", 1'b1, zero_flag)
    run({CIE_OP_OR_FILE, 1'b1, 7'd13});
    `CHK("or file wr", {1'b1, 7'd13, 8'h50}, file_wr)
    `CHK("or file z", 1'b0, zero_flag)
    // a literal or lands in the slot and must vanish
    drive({CIE_OP_BRANCH, 11'h5a5});
    drive({CIE_OP_OR_LIT, 8'hff});
    @(posedge clock);
    insn_valid <= 1'b0;
    #1;
    `CHK("branch pc", {4'h5, 11'h5a5}, pc)
    `CHK("slot w", 8'h00, working)
  endtask
  task automatic t_ret_rot();
    u_mem.mem[14] = 8'he6;
    run(CIE_OP_RETURN);
    `CHK("ret pc", 15'h1234, pc)
    `CHK("ret pop", 1'b1, stack_pop)
    run({CIE_OP_RET_LIT, 8'h3c});
    `CHK("ret lit", {15'h0456, 8'h3c}, {pc, working})
    run(CIE_OP_RET_INT);
    `CHK("ret int", {15'h7abc, 1'b1}, {pc, global_interrupt_enable})
    run({CIE_OP_ROT_LEFT, 1'b0, 7'd14});
    `CHK("rot w", {8'hcc, 1'b1}, {working, carry_flag})
    run({CIE_OP_ROT_LEFT, 1'b1, 7'd14});
    `CHK("rot wr", {1'b1, 7'd14, 8'hcd}, file_wr)
  endtask
  initial begin
    u_mem.stk[2] = 15'h1234;
    u_mem.stk[1] = 15'h0456;
    u_mem.stk[0] = 15'h7abc;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_skip();
    t_or_branch();
    t_ret_rot();
    finish_test();
  end
endmodule // cie_core_bench
`default_nettype wire

/* testbench/cie_partner.sv */
// file registers and return stack facing the core
`timescale 1ns/10ps
`default_nettype none
module cie_partner (
  input wire logic clock,
  input wire logic [6:0] file_raddr,
  input wire cie_pkg::cie_fwr_s file_wr,
  input wire logic stack_pop,
  output logic [7:0] file_rdata,
  output logic [14:0] top_of_stack
);
  logic [7:0] mem [0:127];
  logic [14:0] stk [0:7];
  logic [2:0] sp = 3'd2;
  // same-cycle read, as the core expects
  assign file_rdata = mem[file_raddr];
  assign top_of_stack = stk[sp];
  always @(posedge clock) begin
    if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
    if (stack_pop) sp <= sp - 3'd1;
  end
endmodule // cie_partner
`default_nettype wire
